// file: ddr_ctrl_dual_axi_ports.sv
// fabric-side target ports of the memory controller and their top
`default_nettype none

// ----------------------------------------
// one target port with its own storage
// ----------------------------------------
module ddr_port_engine #(
   parameter int DATA_W    = 256,
   parameter int MEM_WORDS = 256
) (
   input  wire logic                sys_clk,       // clock
   input  wire logic                reset,         // sync reset, high
   input  wire ddr_pkg::request_type req,          // request payload
   input  wire logic                request_valid, // request offered
   output logic                     request_ready, // request can be taken
   input  wire logic [DATA_W-1:0]   wdata,         // write data
   input  wire logic [DATA_W/8-1:0] wstrb,         // byte enables
   input  wire logic [7:0]          wtag,          // write beat tag
   input  wire logic                wlast,         // last write beat
   input  wire logic                wvalid,        // write beat offered
   output logic                     wready,        // write beat can be taken
   output logic                     bvalid,        // write response valid
   output logic [7:0]               btag,          // write response tag
   input  wire logic                bready,        // response taken
   output logic                     rvalid,        // read beat valid
   output logic [DATA_W-1:0]        rdata,         // read data
   output logic [7:0]               rtag,          // read tag
   output logic                     rlast,         // last read beat
   output logic [1:0]               rstat,         // read status
   input  wire logic                rready         // read beat taken
);
   localparam int LANES = DATA_W / 8;
   localparam int LANE_SH = $clog2(LANES);
   localparam int IDX_W = $clog2(MEM_WORDS);

   ddr_pkg::state_type state_ff;
   logic [31:0]        addr_ff;
   logic [8:0]         left_ff;
   logic [7:0]         len_ff;
   logic [2:0]         size_ff;
   logic [1:0]         kind_ff;
   logic [7:0]         tag_ff;
   logic [8:0]         beat_cnt_ff;
   logic [DATA_W-1:0]  mem [MEM_WORDS];

   // wrap bursts fold back inside an aligned window of beats times size
   function automatic logic [31:0] beat_next(input logic [31:0] a, input logic [2:0] sz,
                                             input logic [7:0] len, input logic [1:0] kind);
      logic [31:0] step;
      logic [31:0] span;
      logic [31:0] nxt;
      step = ddr_pkg::ADDR_ONE << sz;
      span = step * ({24'h0, len} + ddr_pkg::ADDR_ONE);
      nxt = a + step;
      case (kind)
         ddr_pkg::BURST_FIXED: beat_next = a;
         ddr_pkg::BURST_WRAP: beat_next = (a & ~(span - ddr_pkg::ADDR_ONE)) | (nxt & (span - ddr_pkg::ADDR_ONE));
         default: beat_next = nxt;
      endcase
   endfunction : beat_next

   wire [31:0] word_idx = addr_ff >> LANE_SH;
   wire        in_range = word_idx < MEM_WORDS;
   // only read when in_range holds, so the cut upper bits never matter
   wire [IDX_W-1:0] mem_idx = word_idx[IDX_W-1:0];
   wire [31:0] nxt_addr = beat_next(addr_ff, size_ff, len_ff, kind_ff);
   wire        take_req = request_valid & request_ready;
   wire        w_beat = wvalid & wready;
   wire        r_beat = rvalid & rready;
   wire        r_load = (state_ff == ddr_pkg::ST_READ) && (left_ff != 9'h0) && (!rvalid || rready);
   wire [8:0]  req_beats = {1'h0, req.burst_beat_count} + 9'h1;

   // ----------------------------------------
   // control
   // ----------------------------------------
   // every port signal on the one port clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_ff <= ddr_pkg::ST_IDLE;
         request_ready <= 1'h1;
         wready <= 1'h0;
         bvalid <= 1'h0;
         rvalid <= 1'h0;
         rlast <= 1'h0;
         left_ff <= 9'h0;
      end else begin
         case (state_ff)
            // take a request only when idle
            ddr_pkg::ST_IDLE: begin
               if (take_req) begin
                  request_ready <= 1'h0;
                  left_ff <= req_beats;
                  if (req.request_type_bit == ddr_pkg::TYPE_WRITE) begin
                     state_ff <= ddr_pkg::ST_WRITE;
                     wready <= 1'h1;
                  end else begin
                     state_ff <= ddr_pkg::ST_READ;
                  end
               end
            end
            // beat moves on write valid and ready
            ddr_pkg::ST_WRITE: begin
               if (w_beat && wlast) begin
                  wready <= 1'h0;
                  bvalid <= 1'h1;
                  state_ff <= ddr_pkg::ST_WRESP;
               end
            end
            ddr_pkg::ST_WRESP: begin
               if (bready) begin
                  bvalid <= 1'h0;
                  request_ready <= 1'h1;
                  state_ff <= ddr_pkg::ST_IDLE;
               end
            end
            // last flag rides the final beat
            ddr_pkg::ST_READ: begin
               if (r_load) begin
                  rvalid <= 1'h1;
                  rlast <= (left_ff == 9'h1);
                  left_ff <= left_ff - 9'h1;
               end else if (r_beat) begin
                  rvalid <= 1'h0;
                  rlast <= 1'h0;
                  if (rlast) begin
                     request_ready <= 1'h1;
                     state_ff <= ddr_pkg::ST_IDLE;
                  end
               end
            end
            default: state_ff <= ddr_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // payload registers and storage
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (take_req) begin
         addr_ff <= req.request_address;
         len_ff <= req.burst_beat_count;
         size_ff <= req.beat_size;
         kind_ff <= req.burst_kind;
         tag_ff <= req.request_tag;
         btag <= req.request_tag;
      end else if (w_beat || r_load) begin
         addr_ff <= nxt_addr;
      end
      if (r_load) begin
         rdata <= in_range ? mem[mem_idx] : '0;
         rtag <= tag_ff;
         rstat <= in_range ? ddr_pkg::RESP_OKAY : ddr_pkg::RESP_SLVERR;
      end
   end

   // out-of-range writes are dropped; the write response still comes back
   always_ff @(posedge sys_clk) begin
      for (int b = 0; b < LANES; b++) begin
         if (w_beat && in_range && wstrb[b]) begin
            mem[mem_idx][b*8 +: 8] <= wdata[b*8 +: 8];
         end
      end
   end

   // helper for the beat count check
   always_ff @(posedge sys_clk) begin
      if (reset || take_req) begin
         beat_cnt_ff <= 9'h0;
      end else if (r_beat) begin
         beat_cnt_ff <= beat_cnt_ff + 9'h1;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_ready_only_idle: assert property (@(posedge sys_clk) disable iff (reset)
      request_ready |-> state_ff == ddr_pkg::ST_IDLE) else $error("request ready outside idle");
   chk_take_drops_ready: assert property (@(posedge sys_clk) disable iff (reset)
      take_req |=> !request_ready) else $error("ready stayed high after take");
   chk_bresp_holds: assert property (@(posedge sys_clk) disable iff (reset)
      bvalid && !bready |=> bvalid && $stable(btag)) else $error("write response dropped early");
   chk_btag_match: assert property (@(posedge sys_clk) disable iff (reset)
      bvalid |-> btag == tag_ff) else $error("write response tag wrong");
   chk_wlast_to_bvalid: assert property (@(posedge sys_clk) disable iff (reset)
      w_beat && wlast |=> bvalid && !wready) else $error("no response after last write beat");
   chk_rbeat_stable: assert property (@(posedge sys_clk) disable iff (reset)
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rlast) && $stable(rstat))
      else $error("read beat changed while stalled");
   chk_rtag_match: assert property (@(posedge sys_clk) disable iff (reset)
      rvalid |-> rtag == tag_ff) else $error("read tag wrong");
   chk_rlast_count: assert property (@(posedge sys_clk) disable iff (reset)
      r_beat |-> rlast == (beat_cnt_ff == {1'h0, len_ff})) else $error("read last on wrong beat");
   chk_rstat_range: assert property (@(posedge sys_clk) disable iff (reset)
      r_load |=> rstat == (($past(in_range)) ? ddr_pkg::RESP_OKAY : ddr_pkg::RESP_SLVERR))
      else $error("read status wrong");
endmodule : ddr_port_engine

// ----------------------------------------
// top: two target ports, no phy access
// ----------------------------------------
module ddr_ctrl_dual_axi_ports #(
   parameter int DQ_WIDTH       = 32,
   parameter int PHY_LANE_MBPS  = 1066,
   parameter int MEM_WORDS      = 256
) (
   input  wire logic                               sys_clk,         // clock for both ports
   input  wire logic                               reset,           // sync reset, high
   input  wire ddr_pkg::request_type               p0_req,          // port 0 request
   input  wire logic                               p0_request_valid, // port 0 request offered
   output logic                                    p0_request_ready, // port 0 request taken
   input  wire logic [ddr_pkg::PORT0_DATA_W-1:0]   p0_wdata,        // port 0 write data
   input  wire logic [ddr_pkg::PORT0_DATA_W/8-1:0] p0_wstrb,        // port 0 byte enables
   input  wire logic [7:0]                         p0_wtag,         // port 0 write tag
   input  wire logic                               p0_wlast,        // port 0 last write beat
   input  wire logic                               p0_wvalid,       // port 0 write valid
   output logic                                    p0_wready,       // port 0 write ready
   output logic                                    p0_bvalid,       // port 0 response valid
   output logic [7:0]                              p0_btag,         // port 0 response tag
   input  wire logic                               p0_bready,       // port 0 response ready
   output logic                                    p0_rvalid,       // port 0 read valid
   output logic [ddr_pkg::PORT0_DATA_W-1:0]        p0_rdata,        // port 0 read data
   output logic [7:0]                              p0_rtag,         // port 0 read tag
   output logic                                    p0_rlast,        // port 0 read last
   output logic [1:0]                              p0_rstat,        // port 0 read status
   input  wire logic                               p0_rready,       // port 0 read ready
   input  wire ddr_pkg::request_type               p1_req,          // port 1 request
   input  wire logic                               p1_request_valid, // port 1 request offered
   output logic                                    p1_request_ready, // port 1 request taken
   input  wire logic [ddr_pkg::PORT1_DATA_W-1:0]   p1_wdata,        // port 1 write data
   input  wire logic [ddr_pkg::PORT1_DATA_W/8-1:0] p1_wstrb,        // port 1 byte enables
   input  wire logic [7:0]                         p1_wtag,         // port 1 write tag
   input  wire logic                               p1_wlast,        // port 1 last write beat
   input  wire logic                               p1_wvalid,       // port 1 write valid
   output logic                                    p1_wready,       // port 1 write ready
   output logic                                    p1_bvalid,       // port 1 response valid
   output logic [7:0]                              p1_btag,         // port 1 response tag
   input  wire logic                               p1_bready,       // port 1 response ready
   output logic                                    p1_rvalid,       // port 1 read valid
   output logic [ddr_pkg::PORT1_DATA_W-1:0]        p1_rdata,        // port 1 read data
   output logic [7:0]                              p1_rtag,         // port 1 read tag
   output logic                                    p1_rlast,        // port 1 read last
   output logic [1:0]                              p1_rstat,        // port 1 read status
   input  wire logic                               p1_rready        // port 1 read ready
);
   // bus width limited to the two package options
   chk_dq_width: assert property (@(posedge sys_clk)
      DQ_WIDTH == ddr_pkg::DQ_WIDTH_NARROW || DQ_WIDTH == ddr_pkg::DQ_WIDTH_WIDE)
      else $error("unsupported memory bus width");
   chk_lane_rate: assert property (@(posedge sys_clk)
      PHY_LANE_MBPS <= ddr_pkg::PHY_MAX_LANE_MBPS) else $error("lane rate above ceiling");

   // wide and narrow port; no path around these engines
   // calibration registers sit behind a separate bus, not here
   ddr_port_engine #(.DATA_W(ddr_pkg::PORT0_DATA_W), .MEM_WORDS(MEM_WORDS)) port0 (
      .sys_clk(sys_clk), .reset(reset), .req(p0_req), .request_valid(p0_request_valid),
      .request_ready(p0_request_ready), .wdata(p0_wdata), .wstrb(p0_wstrb), .wtag(p0_wtag),
      .wlast(p0_wlast), .wvalid(p0_wvalid), .wready(p0_wready), .bvalid(p0_bvalid), .btag(p0_btag),
      .bready(p0_bready), .rvalid(p0_rvalid), .rdata(p0_rdata), .rtag(p0_rtag), .rlast(p0_rlast),
      .rstat(p0_rstat), .rready(p0_rready));

   ddr_port_engine #(.DATA_W(ddr_pkg::PORT1_DATA_W), .MEM_WORDS(MEM_WORDS)) port1 (
      .sys_clk(sys_clk), .reset(reset), .req(p1_req), .request_valid(p1_request_valid),
      .request_ready(p1_request_ready), .wdata(p1_wdata), .wstrb(p1_wstrb), .wtag(p1_wtag),
      .wlast(p1_wlast), .wvalid(p1_wvalid), .wready(p1_wready), .bvalid(p1_bvalid), .btag(p1_btag),
      .bready(p1_bready), .rvalid(p1_rvalid), .rdata(p1_rdata), .rtag(p1_rtag), .rlast(p1_rlast),
      .rstat(p1_rstat), .rready(p1_rready));
endmodule : ddr_ctrl_dual_axi_ports
`default_nettype wire

// file: ddr_pkg.sv
// constants and carrier types for the dual-port fabric-side memory controller
// How it works
// - memory data bus is sixteen or thirty-two bits, fixed per package.
// - phy lanes carry up to 1066 Mbps for every memory standard.
// - two target ports: port 0 is 256 bits, port 1 is 128 bits.
// - fabric never reaches the phy; all access goes through the controller.
// - configuration registers are read and written over the calibration bus.
// - every port signal is sampled and driven in its port clock.
// - request ready only when a request can be taken; valid and ready take it.
// - each beat address follows from burst kind and beat size.
// - write response valid with its tag, held until response ready.
// - read beats carry the request tag; read last only on final beat.
// - every read beat carries a 2-bit status code.
// - read data is 256 bits on port 0, 128 bits on port 1.
// - a write beat moves when write valid and write ready are high.
`default_nettype none
package ddr_pkg;
   // ----------------------------------------
   // widths and phy figures
   // ----------------------------------------
   localparam int PORT0_DATA_W = 256;
   localparam int PORT1_DATA_W = 128;
   localparam int DQ_WIDTH_NARROW = 16;
   localparam int DQ_WIDTH_WIDE = 32;
   localparam int PHY_MAX_LANE_MBPS = 1066;
   localparam int MEM_WORDS_DEFAULT = 256;

   // ----------------------------------------
   // encodings
   // ----------------------------------------
   localparam logic       TYPE_READ = 1'h0;
   localparam logic       TYPE_WRITE = 1'h1;
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [1:0] BURST_WRAP = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] ADDR_ONE = 32'h1;

   typedef struct packed {
      logic        request_type_bit;
      logic [31:0] request_address;
      logic [7:0]  request_tag;
      logic [7:0]  burst_beat_count;
      logic [2:0]  beat_size;
      logic [1:0]  burst_kind;
      logic [1:0]  lock_kind;
   } request_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_WRESP = 2'b10,
      ST_READ  = 2'b11
   } state_type;
endpackage : ddr_pkg
`default_nettype wire

// file: fabric_master_model.sv
// fabric master model: read-ready and response-ready of one target port
`default_nettype none
module fabric_master_model (
   input  wire logic sys_clk, // clock
   input  wire logic reset,   // sync reset, high
   input  wire logic stall,   // alternate the ready signals when high
   output logic      rready,  // read beat ready
   output logic      bready   // write response ready
);
   timeunit 1ns;
   timeprecision 100ps;

   logic phase_ff;

   // ----------------------------------------
   // ready generation
   // ----------------------------------------
   // changes only at the port clock edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         phase_ff <= 1'h0;
      end else begin
         phase_ff <= ~phase_ff;
      end
   end

   // ready only while the model can take data
   assign rready = ~stall | phase_ff;
   // stalling the response makes the controller hold it
   assign bready = ~stall | ~phase_ff;
endmodule : fabric_master_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the dual-port memory controller target ports
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 sys_clk, reset;
   ddr_pkg::request_type rq [2];
   logic                 rqv [2], rqr [2], wl [2], wv [2], wrdy [2], bv [2], br [2];
   logic                 rv [2], rl [2], rr [2], stall [2];
   logic [255:0]         wd [2], rd [2], emem [2][256];
   logic [127:0]         rd_narrow;
   assign rd[1] = {128'h0, rd_narrow};
   logic [31:0]          ws [2];
   logic [7:0]           wt [2], bt [2], rt [2];
   logic [1:0]           rs [2];
   int                   error_cnt, compares;

   ddr_ctrl_dual_axi_ports DUT (
      .sys_clk(sys_clk), .reset(reset),
      .p0_req(rq[0]), .p0_request_valid(rqv[0]), .p0_request_ready(rqr[0]),
      .p0_wdata(wd[0]), .p0_wstrb(ws[0]), .p0_wtag(wt[0]), .p0_wlast(wl[0]),
      .p0_wvalid(wv[0]), .p0_wready(wrdy[0]), .p0_bvalid(bv[0]), .p0_btag(bt[0]),
      .p0_bready(br[0]), .p0_rvalid(rv[0]), .p0_rdata(rd[0]), .p0_rtag(rt[0]),
      .p0_rlast(rl[0]), .p0_rstat(rs[0]), .p0_rready(rr[0]),
      .p1_req(rq[1]), .p1_request_valid(rqv[1]), .p1_request_ready(rqr[1]),
      .p1_wdata(wd[1][127:0]), .p1_wstrb(ws[1][15:0]), .p1_wtag(wt[1]), .p1_wlast(wl[1]),
      .p1_wvalid(wv[1]), .p1_wready(wrdy[1]), .p1_bvalid(bv[1]), .p1_btag(bt[1]),
      .p1_bready(br[1]), .p1_rvalid(rv[1]), .p1_rdata(rd_narrow), .p1_rtag(rt[1]),
      .p1_rlast(rl[1]), .p1_rstat(rs[1]), .p1_rready(rr[1])
   );
   fabric_master_model pm0 (.sys_clk(sys_clk), .reset(reset), .stall(stall[0]), .rready(rr[0]), .bready(br[0]));
   fabric_master_model pm1 (.sys_clk(sys_clk), .reset(reset), .stall(stall[1]), .rready(rr[1]), .bready(br[1]));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic send_req(input int p, input logic typ, input int word, input int beats,
                           input logic [1:0] kind, input logic [7:0] tag);
      int n;
      rq[p] = '{typ, 32'(word * (p ? 16 : 32)), tag, 8'(beats - 1), p ? 3'h4 : 3'h5, kind, 2'h0};
      rqv[p] = 1'h1;
      for (n = 0; n < 50 && rqr[p] !== 1'h1; n++) tick;
      tick;
      rqv[p] = 1'h0;
      chk("request_ready busy", 1'h0, rqr[p]);
   endtask : send_req

   task automatic wr(input int p, input int word, input int beats, input logic [7:0] tag,
                     input logic [31:0] seed, input logic [31:0] strb);
      int i, b, n;
      send_req(p, ddr_pkg::TYPE_WRITE, word, beats, ddr_pkg::BURST_INCR, tag);
      for (i = 0; i < beats; i++) begin
         wd[p] = {8{seed + 32'(i)}};
         ws[p] = strb;
         wt[p] = tag;
         wl[p] = (i == beats - 1);
         wv[p] = 1'h1;
         for (n = 0; n < 50 && wrdy[p] !== 1'h1; n++) tick;
         tick;
         // only enabled byte lanes reach storage
         for (b = 0; b < (p ? 16 : 32); b++) begin
            if (strb[b] && word + i < 256) begin
               emem[p][word + i][8*b +: 8] = wd[p][8*b +: 8];
            end
         end
      end
      wv[p] = 1'h0;
      wl[p] = 1'h0;
      for (n = 0; n < 50 && !(bv[p] === 1'h1 && br[p] === 1'h1); n++) begin
         b = (bv[p] === 1'h1);
         tick;
         if (b) chk("bvalid held", 1'h1, bv[p]);
      end
      chk("btag", tag, bt[p]);
      tick;
      chk("bvalid cleared", 1'h0, bv[p]);
      chk("request_ready after write", 1'h1, rqr[p]);
   endtask : wr

   task automatic rdt(input int p, input int word, input int beats, input logic [1:0] kind, input logic [7:0] tag);
      int i, n, lo, idx;
      logic [255:0] msk;
      msk = p ? {128'h0, {128{1'b1}}} : '1;
      send_req(p, ddr_pkg::TYPE_READ, word, beats, kind, tag);
      lo = word - word % beats;
      for (i = 0; i < beats; i++) begin
         idx = word + i;
         if (kind == ddr_pkg::BURST_FIXED) begin
            idx = word;
         end else if (kind == ddr_pkg::BURST_WRAP) begin
            idx = lo + (word - lo + i) % beats;
         end
         for (n = 0; n < 50 && !(rv[p] === 1'h1 && rr[p] === 1'h1); n++) tick;
         chk("rdata", idx < 256 ? emem[p][idx] & msk : '0, rd[p] & msk);
         chk("rtag", tag, rt[p]);
         chk("rstat", idx < 256 ? ddr_pkg::RESP_OKAY : ddr_pkg::RESP_SLVERR, rs[p]);
         chk("rlast", i == beats - 1, rl[p]);
         tick;
      end
      tick;
      chk("request_ready after read", 1'h1, rqr[p]);
   endtask : rdt

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset;
      int p;
      for (p = 0; p < 2; p++) begin
         chk("request_ready idle", 1'h1, rqr[p]);
         chk("wready idle", 1'h0, wrdy[p]);
         chk("bvalid idle", 1'h0, bv[p]);
         chk("rvalid idle", 1'h0, rv[p]);
      end
      $display("test reset done");
   endtask : test_reset

   task automatic test_port0_incr;
      stall[0] = 1'h1;
      wr(0, 0, 4, 8'h11, 32'hA000_0000, 32'hFFFF_FFFF);
      wr(0, 1, 1, 8'h12, 32'h5C00_0000, 32'h0000_FFFF);
      rdt(0, 0, 4, ddr_pkg::BURST_INCR, 8'h13);
      stall[0] = 1'h0;
      $display("test port0 incr done");
   endtask : test_port0_incr

   task automatic test_burst_kinds;
      rdt(0, 2, 4, ddr_pkg::BURST_WRAP, 8'h21);
      rdt(0, 1, 2, ddr_pkg::BURST_FIXED, 8'h22);
      $display("test burst kinds done");
   endtask : test_burst_kinds

   task automatic test_out_of_range;
      // the second beat lands past the storage and is dropped
      wr(0, 255, 2, 8'h30, 32'hC300_0000, 32'hFFFF_FFFF);
      rdt(0, 255, 2, ddr_pkg::BURST_INCR, 8'h31);
      $display("test out of range done");
   endtask : test_out_of_range

   task automatic test_port1;
      stall[1] = 1'h1;
      wr(1, 3, 2, 8'h41, 32'hB100_0000, 32'h0000_FFFF);
      rdt(1, 3, 2, ddr_pkg::BURST_INCR, 8'h42);
      rdt(1, 256, 1, ddr_pkg::BURST_INCR, 8'h43);
      stall[1] = 1'h0;
      $display("test port1 done");
   endtask : test_port1

   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   // stands for the pll-fed clock
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   // all scenarios need well under a thousand cycles
   initial begin
      #50000;
      error_cnt++;
      $display("watchdog expired");
      conclude;
   end

   initial begin
      reset = 1'h1;
      error_cnt = 0;
      compares = 0;
      for (int p = 0; p < 2; p++) begin
         rq[p] = '0;
         rqv[p] = 1'h0;
         wd[p] = '0;
         ws[p] = '0;
         wt[p] = '0;
         wl[p] = 1'h0;
         wv[p] = 1'h0;
         stall[p] = 1'h0;
      end
      repeat (8) @(posedge sys_clk);
      #1;
      reset = 1'h0;
      test_reset;
      test_port0_incr;
      test_burst_kinds;
      test_out_of_range;
      test_port1;
      conclude;
   end
endmodule : tb_top
`default_nettype wire
